// ==== core/tesc_pkg.sv ====
// Purpose: constants and types of the transmit envelope encoder
// Assumes: 40 MHz pclk, APB register access
// Notes: register index times four gives the byte address
// Operation
// RULE_01: per-byte mode frames every data byte separately
// RULE_02: per-byte mode retriggers itself after each byte
// RULE_03: stream mode frames all queued bytes once
// RULE_04: miller enable applies modified Miller pulses
// RULE_05: pulse position selects none, start, half, three quarters; code 3h starts the pulse at three quarters of the bit
// RULE_06: software sets pulse position 1h with Miller
// RULE_07: invert bit inverts the data envelope
// RULE_08: envelope type shapes the pseudo bit stream
// RULE_09: codes 0h-3h direct, Manchester, subcarrier, BPSK
// RULE_10: codes 4h, 5h give half-bit return-to-zero pulses
// RULE_11: bit 7 picks upper pair subcarrier frequency
// RULE_12: bit 3 picks lower pair subcarrier frequency
// RULE_13: upper pair bitrate code maps to stream rate
// RULE_14: lower pair bitrate code uses same mapping
// RULE_15: two bytes form the first 16-bit pattern
// RULE_16: two bytes form the second 16-bit pattern
// RULE_17: high byte upper eight bits, low byte lower
// RULE_18: length field limits used pattern bits, 1-16
// RULE_19: configuration takes effect at next transmission start; the upper pair timing outputs follow sym_freq one cycle after each write
package tesc_pkg;
    localparam logic [7:0] IDX_DATA_MOD = 8'h4b;
    localparam logic [7:0] IDX_SYM_FREQ = 8'h4c;
    localparam logic [7:0] IDX_P0_HIGH = 8'h4d;
    localparam logic [7:0] IDX_P0_LOW = 8'h4e;
    localparam logic [7:0] IDX_P1_HIGH = 8'h4f;
    localparam logic [7:0] IDX_P1_LOW = 8'h50;
    localparam logic [7:0] IDX_CONTROL = 8'h60;
    localparam logic [7:0] IDX_LENGTH = 8'h61;
    localparam logic [7:0] IDX_STATUS = 8'h62;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    localparam int POS_FRAME_STEP = 7;
    localparam int POS_MILLER = 6;
    localparam int POS_PULSE = 4;
    localparam int POS_INVERT = 3;
    localparam int POS_ENV = 0;
    localparam int POS_UPPER_SC = 7;
    localparam int POS_UPPER_RATE = 4;
    localparam int POS_LOWER_SC = 3;
    localparam int POS_LOWER_RATE = 0;
    localparam int POS_START = 0;
    localparam int CLK_KHZ = 40000;
    localparam int SC_LOW_KHZ = 424;
    localparam int SC_HIGH_KHZ = 848;
    localparam int RATE_26_KHZ = 26;
    localparam int RATE_53_KHZ = 53;
    localparam int RATE_106_KHZ = 106;
    localparam int RATE_212_KHZ = 212;
    localparam int RATE_424_KHZ = 424;
    localparam int RATE_848_KHZ = 848;
    localparam int BYTE_LAST_BIT = 7;
    typedef enum logic [2:0] {
        ENV_DIRECT, ENV_MANCH, ENV_MANCH_SC, ENV_BPSK,
        ENV_RZ_LATE, ENV_RZ_EARLY, ENV_RES6, ENV_RES7
    } tesc_env_t;
    typedef struct packed {
        logic per_byte;
        logic miller;
        logic [1:0] pulse;
        logic invert;
        tesc_env_t env;
        logic sc_sel;
        logic [2:0] rate;
        logic [15:0] pat0;
        logic [15:0] pat1;
        logic [3:0] len0;
        logic [3:0] len1;
    } tesc_cfg_t;
endpackage

// ==== core/tesc_top.sv ====
// Purpose: APB configured transmit envelope encoder
// Assumes: inputs synchronous to pclk, zero wait-state APB
// Notes: first pattern opens a frame, second pattern closes it
`timescale 1ns/100ps
`default_nettype none
module tesc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] tx_byte,
    input wire logic tx_byte_valid,
    output logic tx_byte_ready,
    output logic tx_envelope,
    output logic tx_active,
    output logic [11:0] upper_bit_cycles,
    output logic [7:0] upper_sc_half_cycles
);
    import tesc_pkg::*;
    typedef enum logic [1:0] {S_IDLE, S_SOF, S_DATA, S_EOF} tesc_state_t;
    function automatic logic [11:0] bit_cycles(input logic [2:0] code);
        int k;
        k = RATE_106_KHZ;
        case (code)
            3'h2: k = RATE_26_KHZ;
            3'h3: k = RATE_53_KHZ;
            3'h4: k = RATE_106_KHZ;
            3'h5: k = RATE_212_KHZ;
            3'h6: k = RATE_424_KHZ;
            3'h7: k = RATE_848_KHZ;
            default: k = RATE_106_KHZ;
        endcase
        return 12'(CLK_KHZ / k);
    endfunction
    function automatic logic [7:0] sc_half(input logic sel);
        return sel ? 8'(CLK_KHZ / (2 * SC_HIGH_KHZ))
                   : 8'(CLK_KHZ / (2 * SC_LOW_KHZ));
    endfunction
    function automatic logic mapped(input logic [7:0] idx);
        if (idx >= IDX_DATA_MOD && idx <= IDX_P1_LOW) begin
            return 1'b1;
        end else if (idx >= IDX_CONTROL && idx <= IDX_STATUS) begin
            return 1'b1;
        end else begin
            return 1'b0;
        end
    endfunction
    logic [7:0] data_mod, sym_freq, p0_high, p0_low, p1_high, p1_low;
    logic [7:0] lengths, idx, sc_cnt, shreg;
    logic wr, rd, start_req, bit_end, sc, prev_bit;
    tesc_state_t state;
    tesc_cfg_t cfg, live_cfg;
    logic [7:0] buf_mem [2];
    logic buf_wp, buf_rp, buf_valid, buf_pop;
    logic [1:0] buf_cnt;
    logic [11:0] phase, period, pstart;
    logic [3:0] sym_idx;
    logic [2:0] bit_cnt;
    logic cur_bit, half, pwin, env, next_env;
    assign idx = paddr[9:2];
    assign wr = psel && penable && pwrite;
    assign rd = psel && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped(idx);
    assign start_req = wr && idx == IDX_CONTROL && pwdata[POS_START];
    // register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_mod <= RESET_VALUE;
            sym_freq <= RESET_VALUE;
            p0_high <= RESET_VALUE;
            p0_low <= RESET_VALUE;
            p1_high <= RESET_VALUE;
            p1_low <= RESET_VALUE;
            lengths <= RESET_VALUE;
        end else if (wr) begin
            if (idx == IDX_DATA_MOD) begin
                data_mod <= pwdata[7:0];
            end else if (idx == IDX_SYM_FREQ) begin
                sym_freq <= pwdata[7:0];
            end else if (idx == IDX_P0_HIGH) begin
                p0_high <= pwdata[7:0];
            end else if (idx == IDX_P0_LOW) begin
                p0_low <= pwdata[7:0];
            end else if (idx == IDX_P1_HIGH) begin
                p1_high <= pwdata[7:0];
            end else if (idx == IDX_P1_LOW) begin
                p1_low <= pwdata[7:0];
            end else if (idx == IDX_LENGTH) begin
                lengths <= pwdata[7:0];
            end
        end
    end
    // read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (rd) begin
            prdata <= '0;
            if (idx == IDX_DATA_MOD) begin
                prdata[7:0] <= data_mod;
            end else if (idx == IDX_SYM_FREQ) begin
                prdata[7:0] <= sym_freq;
            end else if (idx == IDX_P0_HIGH) begin
                prdata[7:0] <= p0_high;
            end else if (idx == IDX_P0_LOW) begin
                prdata[7:0] <= p0_low;
            end else if (idx == IDX_P1_HIGH) begin
                prdata[7:0] <= p1_high;
            end else if (idx == IDX_P1_LOW) begin
                prdata[7:0] <= p1_low;
            end else if (idx == IDX_LENGTH) begin
                prdata[7:0] <= lengths;
            end else if (idx == IDX_STATUS) begin
                prdata[3:0] <= {buf_cnt, state != S_IDLE, tx_envelope};
            end
        end
    end
    // live configuration view
    always_comb begin
        live_cfg.per_byte = data_mod[POS_FRAME_STEP];
        live_cfg.miller = data_mod[POS_MILLER];
        live_cfg.pulse = data_mod[POS_PULSE +: 2];
        live_cfg.invert = data_mod[POS_INVERT];
        live_cfg.env = tesc_env_t'(data_mod[POS_ENV +: 3]);
        live_cfg.sc_sel = sym_freq[POS_LOWER_SC]; // RULE_12
        live_cfg.rate = sym_freq[POS_LOWER_RATE +: 3];
        live_cfg.pat0 = {p0_high, p0_low}; // RULE_15 RULE_17
        live_cfg.pat1 = {p1_high, p1_low}; // RULE_16 RULE_17
        live_cfg.len0 = lengths[3:0];
        live_cfg.len1 = lengths[7:4];
    end
    // snapshot at transmission start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= '0;
        end else if (state == S_IDLE && start_req) begin
            cfg <= live_cfg; // RULE_19
        end
    end
    // upper pair timing for the symbol generator
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upper_bit_cycles <= '0;
            upper_sc_half_cycles <= '0;
        end else begin
            upper_bit_cycles <= bit_cycles(sym_freq[POS_UPPER_RATE +: 3]); // RULE_13
            upper_sc_half_cycles <= sc_half(sym_freq[POS_UPPER_SC]); // RULE_11
        end
    end
    // two-entry byte buffer
    assign buf_valid = buf_cnt != 2'd0;
    assign tx_byte_ready = buf_cnt != 2'd2;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_wp <= 1'b0;
            buf_rp <= 1'b0;
            buf_cnt <= 2'd0;
        end else begin
            if (tx_byte_valid && tx_byte_ready) begin
                buf_wp <= !buf_wp;
            end
            if (buf_pop) begin
                buf_rp <= !buf_rp;
            end
            buf_cnt <= buf_cnt + 2'(tx_byte_valid && tx_byte_ready)
                - 2'(buf_pop);
        end
    end
    always_ff @(posedge pclk) begin
        if (tx_byte_valid && tx_byte_ready) begin
            buf_mem[buf_wp] <= tx_byte;
        end
    end
    // bit and subcarrier timing
    assign period = bit_cycles(cfg.rate); // RULE_14
    assign bit_end = phase == period - 12'd1;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= '0;
        end else if (state == S_IDLE || bit_end) begin
            phase <= '0;
        end else begin
            phase <= phase + 12'd1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sc_cnt <= '0;
            sc <= 1'b0;
        end else if (state == S_IDLE) begin
            sc_cnt <= '0;
            sc <= 1'b0;
        end else if (sc_cnt == sc_half(cfg.sc_sel) - 8'd1) begin
            sc_cnt <= '0;
            sc <= !sc;
        end else begin
            sc_cnt <= sc_cnt + 8'd1;
        end
    end
    // frame sequencer
    assign buf_pop = bit_end && buf_valid && (
        (state == S_SOF && sym_idx == 4'd0) ||
        (state == S_DATA && bit_cnt == 3'd0 && !cfg.per_byte)); // RULE_03
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= S_IDLE;
            sym_idx <= '0;
            bit_cnt <= '0;
            shreg <= '0;
            prev_bit <= 1'b0;
        end else begin
            case (state)
                S_IDLE: begin
                    if (start_req) begin
                        state <= S_SOF;
                        sym_idx <= live_cfg.len0; // RULE_18
                    end
                end
                S_SOF: begin
                    if (bit_end) begin
                        sym_idx <= sym_idx - 4'd1;
                        prev_bit <= 1'b0;
                        if (sym_idx == 4'd0) begin
                            if (buf_valid) begin
                                state <= S_DATA;
                                bit_cnt <= 3'(BYTE_LAST_BIT);
                                shreg <= buf_mem[buf_rp];
                            end else begin
                                state <= S_EOF;
                                sym_idx <= cfg.len1; // RULE_18
                            end
                        end
                    end
                end
                S_DATA: begin
                    if (bit_end) begin
                        prev_bit <= shreg[0];
                        shreg <= shreg >> 1;
                        bit_cnt <= bit_cnt - 3'd1;
                        if (bit_cnt == 3'd0) begin
                            if (buf_pop) begin
                                bit_cnt <= 3'(BYTE_LAST_BIT); // RULE_03
                                shreg <= buf_mem[buf_rp];
                            end else begin
                                state <= S_EOF; // RULE_01
                                sym_idx <= cfg.len1;
                            end
                        end
                    end
                end
                S_EOF: begin
                    if (bit_end) begin
                        sym_idx <= sym_idx - 4'd1;
                        if (sym_idx == 4'd0) begin
                            if (cfg.per_byte && buf_valid) begin
                                state <= S_SOF; // RULE_02
                                sym_idx <= cfg.len0;
                            end else begin
                                state <= S_IDLE;
                            end
                        end
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
    // envelope shaping
    assign cur_bit = shreg[0];
    assign half = phase >= (period >> 1);
    always_comb begin
        pstart = '0;
        env = 1'b0;
        case (cfg.pulse)
            2'd2: pstart = period >> 1;
            2'd3: pstart = (period >> 1) + (period >> 2);
            default: pstart = '0;
        endcase
        if (cfg.miller) begin
            pstart = cur_bit ? (period >> 1) : '0; // RULE_04
        end
        pwin = phase >= pstart && phase < pstart + (period >> 2);
        case (cfg.env)
            ENV_DIRECT: env = cur_bit; // RULE_08 RULE_09
            ENV_MANCH: env = cur_bit ^ half; // RULE_09
            ENV_MANCH_SC: env = (cur_bit ^ half) & sc; // RULE_09
            ENV_BPSK: env = sc ^ !cur_bit; // RULE_09
            ENV_RZ_LATE: env = cur_bit & half; // RULE_10
            ENV_RZ_EARLY: env = cur_bit & !half; // RULE_10
            default: env = 1'b0;
        endcase
        if (cfg.miller) begin
            env = pwin && (cur_bit || !prev_bit); // RULE_04
        end else if (cfg.pulse != 2'd0) begin
            env = env & pwin; // RULE_05
        end
        next_env = 1'b0;
        if (state == S_SOF) begin
            next_env = cfg.pat0[sym_idx];
        end else if (state == S_EOF) begin
            next_env = cfg.pat1[sym_idx];
        end else if (state == S_DATA) begin
            next_env = env ^ cfg.invert; // RULE_07
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_envelope <= 1'b0;
            tx_active <= 1'b0;
        end else begin
            tx_envelope <= next_env;
            tx_active <= state != S_IDLE;
        end
    end
    sequence s_byte_done;
        state == S_DATA && bit_end && bit_cnt == 3'd0;
    endsequence
    sequence s_eof_done;
        state == S_EOF && bit_end && sym_idx == 4'd0;
    endsequence
    a_byte_own_frame: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
        s_byte_done ##0 cfg.per_byte |=> state == S_EOF)
        else $error("byte not closed in per-byte mode");
    a_auto_retrigger: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
        s_eof_done ##0 (cfg.per_byte && buf_valid) |=> state == S_SOF)
        else $error("no internal retrigger after byte");
    a_stream_continue: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
        s_byte_done ##0 (!cfg.per_byte && buf_valid)
        |=> state == S_DATA && bit_cnt == 3'd7)
        else $error("stream broken between bytes");
    a_miller_zero_gap: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
        state == S_DATA && cfg.miller && !cur_bit && prev_bit
        |=> tx_envelope == cfg.invert)
        else $error("miller zero after one pulsed");
    a_pulse_window: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
        state == S_DATA && !cfg.miller && cfg.pulse == 2'd1
        && phase >= (period >> 2) |=> tx_envelope == cfg.invert)
        else $error("pulse outside first quarter");
    a_direct_invert: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
        state == S_DATA && !cfg.miller && cfg.pulse == 2'd0
        && cfg.env == ENV_DIRECT |=> tx_envelope == $past(cur_bit ^ cfg.invert))
        else $error("direct envelope wrong");
    a_rz_late_low: assert property (@(posedge pclk) disable iff (!presetn) // RULE_10
        state == S_DATA && !cfg.miller && cfg.pulse == 2'd0
        && cfg.env == ENV_RZ_LATE && phase == 12'd0
        |=> tx_envelope == cfg.invert)
        else $error("rz pulse in first half");
    a_cfg_frozen: assert property (@(posedge pclk) disable iff (!presetn) // RULE_19
        state != S_IDLE && $past(state) != S_IDLE |-> $stable(cfg))
        else $error("config changed mid frame");
    a_sof_length: assert property (@(posedge pclk) disable iff (!presetn) // RULE_18
        state == S_IDLE && start_req
        |=> state == S_SOF && sym_idx == $past(lengths[3:0]))
        else $error("start pattern length not loaded");
endmodule // tesc_top
`default_nettype wire

// ==== verif/tesc_rf_model.sv ====
// Purpose: modulator model sampling the transmit envelope
// Assumes: fixed bit length in pclk cycles while tx_active is high
// Notes: two samples per bit, at one and three quarters
`timescale 1ns/100ps
`default_nettype none
module tesc_rf_model #(
    parameter int BIT_CYCLES = 47
) (
    input wire logic pclk,
    input wire logic tx_envelope,
    input wire logic tx_active
);
    logic q_a[$];
    logic q_b[$];
    int cnt = 0;
    // bit clock restarts whenever tx_active drops, not between retriggered per-byte frames
    always @(posedge pclk) begin
        if (tx_active !== 1'b1) begin
            cnt <= 0;
        end else begin
            if (cnt == BIT_CYCLES / 4) begin
                q_a.push_back(tx_envelope);
            end
            if (cnt == 3 * BIT_CYCLES / 4) begin
                q_b.push_back(tx_envelope);
            end
            cnt <= (cnt == BIT_CYCLES - 1) ? 0 : cnt + 1;
        end
    end
endmodule // tesc_rf_model
`default_nettype wire

// ==== verif/tb.sv ====
// Purpose: self-checking bench of the transmit envelope encoder
// Assumes: zero wait-state APB, lower pair rate code 7 for data
// Notes: frames judged from quarter-bit samples of the model
`timescale 1ns/100ps
`default_nettype none
module tb;
    import tesc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, tx_byte_valid;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, tx_byte_ready, tx_envelope, tx_active;
    logic [7:0] tx_byte, upper_sc_half_cycles;
    logic [11:0] upper_bit_cycles;
    int n_errors = 0;
    int comparisons = 0;
    tesc_top u_tesc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid),
        .tx_byte_ready(tx_byte_ready), .tx_envelope(tx_envelope),
        .tx_active(tx_active), .upper_bit_cycles(upper_bit_cycles),
        .upper_sc_half_cycles(upper_sc_half_cycles));
    tesc_rf_model u_tesc_rf_model (.pclk(pclk), .tx_envelope(tx_envelope),
        .tx_active(tx_active));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic test_done;
        if (n_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic chk_bit(input string s, input logic e, g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %b seen %b", s, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] idx,
        input logic [7:0] d, output logic [31:0] r, output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        r = prdata;
        e = pslverr;
        chk_bit("apb_ready", 1'b1, pready);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, d, r, e);
    endtask
    task automatic regs_test;
        logic [31:0] r;
        logic e;
        logic [7:0] idx[7];
        idx = '{IDX_DATA_MOD, IDX_SYM_FREQ, IDX_P0_HIGH, IDX_P0_LOW,
            IDX_P1_HIGH, IDX_P1_LOW, IDX_LENGTH};
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, idx[i], 8'h00, r, e);
            chk("reset_value", 32'h0, r);
            wr(idx[i], {4'ha, 4'(i)});
            apb(1'b0, idx[i], 8'h00, r, e);
            chk("readback", {24'h0, 4'ha, 4'(i)}, r);
        end
        apb(1'b0, IDX_CONTROL, 8'h00, r, e);
        chk("control_read", 32'h0, r);
        apb(1'b0, 8'h70, 8'h00, r, e);
        chk("unmapped_err", 32'h1, {31'h0, e});
        chk("unmapped_data", 32'h0, r);
    endtask
    task automatic upper_rate_test;
        int cyc[6] = '{1538, 754, 377, 188, 94, 47};
        for (int c = 2; c < 8; c++) begin
            wr(IDX_SYM_FREQ, {c[0], 3'(c), 4'h7});
            repeat (3) @(posedge pclk);
            chk("upper_bit", 32'(cyc[c-2]), {20'h0, upper_bit_cycles});
            chk("upper_sc", c[0] ? 32'd23 : 32'd47,
                {24'h0, upper_sc_half_cycles});
        end
    endtask
    task automatic chk_pat(input logic [15:0] p, input logic [3:0] l,
        inout int k);
        for (int i = int'(l); i >= 0; i--) begin
            chk_bit("pattern_a", p[i], u_tesc_rf_model.q_a[k]);
            chk_bit("pattern_b", p[i], u_tesc_rf_model.q_b[k]);
            k++;
        end
    endtask
    task automatic chk_data(input logic [7:0] b, input logic [2:0] env,
        input logic inv, inout int k, inout logic [1:0] rf);
        logic a, c;
        for (int i = 0; i < 8; i++) begin
            a = u_tesc_rf_model.q_a[k];
            c = u_tesc_rf_model.q_b[k];
            k++;
            if (rf[1] === 1'bx) begin
                rf = {inv, inv};
            end
            case (env)
                3'h0: begin
                    chk_bit("direct_a", b[i] ^ inv, a);
                    chk_bit("direct_b", b[i] ^ inv, c);
                end
                3'h1: begin
                    chk_bit("manchester", 1'b1, a ^ c);
                    chk_bit("manchester_a", b[i] ^ inv, a);
                end
                3'h2: begin
                    chk_bit("manch_sc_a", (b[i] & i[0]) ^ inv, a);
                    chk_bit("manch_sc_b", (!b[i] & i[0]) ^ inv, c);
                end
                3'h3: chk_bit("bpsk", i[0] ^ !b[i] ^ inv, a);
                3'h4: begin
                    chk_bit("rz_late_idle", rf[1], a);
                    chk_bit("rz_late_pulse", rf[0], c ^ b[i]);
                end
                3'h5: begin
                    chk_bit("rz_early_idle", rf[1], c);
                    chk_bit("rz_early_pulse", rf[0], a ^ b[i]);
                end
                3'h7: begin
                    chk_bit("pulse_quiet_a", inv, a);
                    chk_bit("pulse_quiet_b", inv, c);
                end
                default: ;
            endcase
        end
    endtask
    task automatic run_frame(input logic [7:0] dmod, later, len, b0, b1);
        logic [31:0] r;
        logic e;
        logic [1:0] rf;
        logic [2:0] env;
        int k, n, nb;
        wr(IDX_DATA_MOD, dmod);
        wr(IDX_LENGTH, len);
        wr(IDX_SYM_FREQ, 8'h07);
        wr(IDX_P0_HIGH, 8'ha5);
        wr(IDX_P0_LOW, 8'hc3);
        wr(IDX_P1_HIGH, 8'h3c);
        wr(IDX_P1_LOW, 8'h96);
        u_tesc_rf_model.q_a.delete();
        u_tesc_rf_model.q_b.delete();
        tx_byte <= b0;
        tx_byte_valid <= 1'b1;
        for (int j = 0; j < 2; j++) begin
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (tx_byte_ready !== 1'b1 && n < 100);
            chk_bit("byte_ready", 1'b1, tx_byte_ready);
            tx_byte <= b1;
        end
        tx_byte_valid <= 1'b0;
        @(posedge pclk);
        chk_bit("buffer_full", 1'b0, tx_byte_ready);
        wr(IDX_CONTROL, 8'h01);
        if (later != dmod) begin
            repeat (300) @(posedge pclk);
            wr(IDX_DATA_MOD, later);
        end
        n = 0;
        do begin
            apb(1'b0, IDX_STATUS, 8'h00, r, e);
            n++;
        end while (r[1] !== 1'b0 && n < 3000);
        chk_bit("frame_done", 1'b0, r[1]);
        repeat (60) @(posedge pclk);
        nb = int'(len[3:0]) + int'(len[7:4]);
        nb = dmod[7] ? 2 * (nb + 10) : nb + 18;
        chk("bit_count", 32'(nb),
            32'(u_tesc_rf_model.q_a.size()));
        env = (dmod[6:4] == 3'h3) ? 3'h4
            : (dmod[6:4] != 3'h0) ? 3'h7 : dmod[2:0];
        k = 0;
        rf = 2'bxx;
        for (int f = 0; f < (dmod[7] ? 2 : 1); f++) begin
            chk_pat(16'ha5c3, len[3:0], k);
            chk_data(f ? b1 : b0, env, dmod[3], k, rf);
            if (!dmod[7]) chk_data(b1, env, dmod[3], k, rf);
            chk_pat(16'h3c96, len[7:4], k);
        end
    endtask
    task automatic stream_test;
        run_frame(8'h00, 8'h08, 8'hf0, 8'h5a, 8'hc3);
        run_frame(8'h08, 8'h08, 8'h00, 8'h3c, 8'h81);
    endtask
    task automatic per_byte_test;
        run_frame(8'h88, 8'h88, 8'h23, 8'h5a, 8'h96);
    endtask
    task automatic envelope_test;
        logic [7:0] m[8];
        m = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h50, 8'h20, 8'h30};
        for (int i = 0; i < 8; i++) begin
            run_frame(m[i], m[i], 8'h11, 8'h5a, 8'h3c);
        end
    endtask
    initial begin
        repeat (60000) @(posedge pclk);
        n_errors++;
        test_done();
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        tx_byte = 8'h00;
        tx_byte_valid = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        regs_test();
        upper_rate_test();
        stream_test();
        per_byte_test();
        envelope_test();
        test_done();
    end
endmodule // tb
`default_nettype wire
